// ===== hw/sidrm_decode.sv
// module: address decoder splitting the register space into blocks
`timescale 1ns/1ps
module sidrm_decode (
  input wire logic [9:0] addr,
  output sidrm_pkg::sidrm_blk_e blk
);
  import sidrm_pkg::*;

  function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo, input logic [9:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================
  // range decode; gaps fall through to reserved
  always_comb begin
    if (addr <= SIDRM_OFF_TARGET) begin
      blk = SIDRM_BLK_STARTUP;
    end else if (in_rng(addr, SIDRM_OFF_ID0, SIDRM_OFF_ID3)) begin
      blk = SIDRM_BLK_ID;
    end else if (in_rng(addr, SIDRM_SIF_LO, SIDRM_SIF_HI)) begin
      blk = SIDRM_BLK_SIF;
    end else if (in_rng(addr, SIDRM_DPLL_LO, SIDRM_DPLL_HI)) begin
      blk = SIDRM_BLK_DPLL;
    end else if (in_rng(addr, SIDRM_DSTAT_LO, SIDRM_DSTAT_HI)) begin
      blk = SIDRM_BLK_DSTAT;
    end else if (in_rng(addr, SIDRM_GPIO_LO, SIDRM_GPIO_HI)) begin
      blk = SIDRM_BLK_GPIO;
    end else if (addr == SIDRM_GPIS) begin
      blk = SIDRM_BLK_GPIS;
    end else if (in_rng(addr, SIDRM_ODRV_LO, SIDRM_ODRV_HI)) begin
      blk = SIDRM_BLK_ODRV;
    end else if (in_rng(addr, SIDRM_IDIV_LO, SIDRM_IDIV_HI)) begin
      blk = SIDRM_BLK_IDIV;
    end else if (in_rng(addr, SIDRM_FDIV_LO, SIDRM_FDIV_HI)) begin
      blk = SIDRM_BLK_FDIV;
    end else if (in_rng(addr, SIDRM_DSRC_LO, SIDRM_DSRC_HI)) begin
      blk = SIDRM_BLK_DSRC;
    end else if (in_rng(addr, SIDRM_APLL_LO, SIDRM_APLL_HI)) begin
      blk = SIDRM_BLK_APLL;
    end else if (in_rng(addr, SIDRM_PDLA_LO, SIDRM_PDLA_HI)) begin
      blk = SIDRM_BLK_PDLA;
    end else if (in_rng(addr, SIDRM_IMON_LO, SIDRM_IMON_HI)) begin
      blk = SIDRM_BLK_IMON;
    end else if (addr == SIDRM_IEN) begin
      blk = SIDRM_BLK_IEN;
    end else if (in_rng(addr, SIDRM_FACT_LO, SIDRM_FACT_HI)) begin
      blk = SIDRM_BLK_FACT;
    end else if (in_rng(addr, SIDRM_ISTAT_LO, SIDRM_ISTAT_HI)) begin
      blk = SIDRM_BLK_ISTAT;
    end else if (in_rng(addr, SIDRM_GSTAT_LO, SIDRM_GSTAT_HI)) begin
      blk = SIDRM_BLK_GSTAT;
    end else begin
      blk = SIDRM_BLK_RSVD;
    end
  end
endmodule

// ===== hw/sidrm_pkg.sv
// package: constants for the startup and identification register bank
package sidrm_pkg;
  // ==========================================================
  // register offsets (byte addresses on the serial control port)
  localparam logic [9:0] SIDRM_OFF_BOOT_CTRL = 10'h000;
  localparam logic [9:0] SIDRM_OFF_TARGET = 10'h001;
  localparam logic [9:0] SIDRM_OFF_ID0 = 10'h002;
  localparam logic [9:0] SIDRM_OFF_ID1 = 10'h003;
  localparam logic [9:0] SIDRM_OFF_ID2 = 10'h004;
  localparam logic [9:0] SIDRM_OFF_ID3 = 10'h005;
  localparam logic [9:0] SIDRM_OFF_BOOT_STAT = 10'h210;
  // ==========================================================
  // block range bounds of the address decoder
  localparam logic [9:0] SIDRM_SIF_LO = 10'h006;
  localparam logic [9:0] SIDRM_SIF_HI = 10'h007;
  localparam logic [9:0] SIDRM_DPLL_LO = 10'h008;
  localparam logic [9:0] SIDRM_DPLL_HI = 10'h02f;
  localparam logic [9:0] SIDRM_GPIO_LO = 10'h030;
  localparam logic [9:0] SIDRM_GPIO_HI = 10'h038;
  localparam logic [9:0] SIDRM_ODRV_LO = 10'h039;
  localparam logic [9:0] SIDRM_ODRV_HI = 10'h03e;
  localparam logic [9:0] SIDRM_IDIV_LO = 10'h03f;
  localparam logic [9:0] SIDRM_IDIV_HI = 10'h04a;
  localparam logic [9:0] SIDRM_FDIV_LO = 10'h057;
  localparam logic [9:0] SIDRM_FDIV_HI = 10'h062;
  localparam logic [9:0] SIDRM_DSRC_LO = 10'h063;
  localparam logic [9:0] SIDRM_DSRC_HI = 10'h067;
  localparam logic [9:0] SIDRM_APLL_LO = 10'h068;
  localparam logic [9:0] SIDRM_APLL_HI = 10'h06b;
  localparam logic [9:0] SIDRM_PDLA_LO = 10'h06c;
  localparam logic [9:0] SIDRM_PDLA_HI = 10'h070;
  localparam logic [9:0] SIDRM_IMON_LO = 10'h071;
  localparam logic [9:0] SIDRM_IMON_HI = 10'h078;
  localparam logic [9:0] SIDRM_IEN = 10'h079;
  localparam logic [9:0] SIDRM_FACT_LO = 10'h07a;
  localparam logic [9:0] SIDRM_FACT_HI = 10'h07b;
  localparam logic [9:0] SIDRM_ISTAT_LO = 10'h200;
  localparam logic [9:0] SIDRM_ISTAT_HI = 10'h201;
  localparam logic [9:0] SIDRM_DSTAT_LO = 10'h202;
  localparam logic [9:0] SIDRM_DSTAT_HI = 10'h20b;
  localparam logic [9:0] SIDRM_GPIS = 10'h20c;
  localparam logic [9:0] SIDRM_GSTAT_LO = 10'h20d;
  localparam logic [9:0] SIDRM_GSTAT_HI = 10'h212;
  // ==========================================================
  // field positions and reset values
  localparam int SIDRM_RETRY_LSB = 3;
  localparam int SIDRM_SKIP_OTP_BIT = 1;
  localparam int SIDRM_SKIP_EEP_BIT = 0;
  localparam int SIDRM_WIDE_BIT = 7;
  localparam int SIDRM_FAIL_BIT = 0;
  localparam logic [4:0] SIDRM_RETRY_RST = 5'h01;
  localparam logic [3:0] SIDRM_REV_RST = 4'h0;
  // part and variant codes: arbitrary neutral values
  localparam logic [15:0] SIDRM_PART_RST = 16'h1234;
  localparam logic [10:0] SIDRM_VARIANT_RST = 11'h055;
  localparam logic [6:0] SIDRM_EEPROM_BUS_ADDRESS_RST = 7'h50;
  localparam logic [7:0] SIDRM_CRC_BYTE = 8'h84;
  localparam logic [7:0] SIDRM_SPEED_BYTE = 8'h05;
  localparam logic [7:0] SIDRM_OTP_BYTES = 8'h08;
  // ==========================================================
  // decoded block of an address
  typedef enum {
    SIDRM_BLK_STARTUP, SIDRM_BLK_ID, SIDRM_BLK_SIF, SIDRM_BLK_DPLL, SIDRM_BLK_GPIO,
    SIDRM_BLK_ODRV, SIDRM_BLK_IDIV, SIDRM_BLK_FDIV, SIDRM_BLK_DSRC, SIDRM_BLK_APLL,
    SIDRM_BLK_PDLA, SIDRM_BLK_IMON, SIDRM_BLK_IEN, SIDRM_BLK_FACT, SIDRM_BLK_ISTAT,
    SIDRM_BLK_DSTAT, SIDRM_BLK_GPIS, SIDRM_BLK_GSTAT, SIDRM_BLK_RSVD
  } sidrm_blk_e;
endpackage

// ===== hw/sidrm_top.sv
// module: startup control and identification register bank with boot-load sequencing
// ==========================================================
`timescale 1ns/1ps
module sidrm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output sidrm_pkg::sidrm_blk_e reg_blk,
  output logic otp_req,
  output logic [7:0] otp_len,
  input wire logic otp_done,
  output logic eep_req,
  output logic [6:0] eep_dev_addr,
  output logic eep_wide,
  output logic [15:0] eep_offset,
  output logic eep_fast,
  input wire logic eep_lost_arb,
  input wire logic eep_ack,
  input wire logic eep_nack,
  input wire logic [7:0] eep_rdata,
  output logic load_busy,
  output logic load_failed_flag
);
  import sidrm_pkg::*;

  typedef enum {SIDRM_IDLE, SIDRM_OTP, SIDRM_EEP, SIDRM_DONE} sidrm_st_e;

  logic [4:0] eeprom_retry_count_r;
  logic skip_otp_load_r;
  logic skip_eeprom_load_r;
  logic rsvd_r;
  logic eeprom_wide_offset_r;
  logic [6:0] eeprom_bus_address_r;
  logic [3:0] revision_code_r;
  logic [15:0] part_code_r;
  logic [10:0] variant_r;
  sidrm_st_e st_r;
  logic [4:0] tries_r;
  logic [7:0] byte_r;
  logic [7:0] crc_r;
  logic eep_fast_r;
  logic fail_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic acc_ok;
  logic load_last;

  // crc-8 step, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction

  // ==========================================================
  // address decode
  sidrm_decode u_sidrm_decode (
    .addr(reg_addr),
    .blk(reg_blk)
  );

  // accesses blocked while any load runs
  assign load_busy = (st_r != SIDRM_DONE);
  assign acc_ok = !load_busy;
  assign load_last = (byte_r == SIDRM_CRC_BYTE);

  // ==========================================================
  // startup control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_retry_count_r <= SIDRM_RETRY_RST;
      skip_otp_load_r <= 1'b0;
      skip_eeprom_load_r <= 1'b1;
      rsvd_r <= 1'b0;
      eeprom_wide_offset_r <= 1'b0;
      eeprom_bus_address_r <= SIDRM_EEPROM_BUS_ADDRESS_RST;
    end else if (reg_wr && acc_ok) begin
      if (reg_addr == SIDRM_OFF_BOOT_CTRL) begin
        eeprom_retry_count_r <= reg_wdata[SIDRM_RETRY_LSB +: 5];
        rsvd_r <= reg_wdata[2];
        skip_otp_load_r <= reg_wdata[SIDRM_SKIP_OTP_BIT];
        skip_eeprom_load_r <= reg_wdata[SIDRM_SKIP_EEP_BIT];
      end else if (reg_addr == SIDRM_OFF_TARGET) begin
        eeprom_wide_offset_r <= reg_wdata[SIDRM_WIDE_BIT];
        eeprom_bus_address_r <= reg_wdata[6:0];
      end
    end
  end

  // ==========================================================
  // identification registers, writable as documented
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      revision_code_r <= SIDRM_REV_RST;
      part_code_r <= SIDRM_PART_RST;
      variant_r <= SIDRM_VARIANT_RST;
    end else if (reg_wr && acc_ok) begin
      unique case (reg_addr)
        SIDRM_OFF_ID0: begin
          revision_code_r <= reg_wdata[7:4];
          part_code_r[15:12] <= reg_wdata[3:0];
        end
        SIDRM_OFF_ID1: part_code_r[11:4] <= reg_wdata;
        SIDRM_OFF_ID2: begin
          part_code_r[3:0] <= reg_wdata[7:4];
          variant_r[10:7] <= reg_wdata[3:0];
        end
        SIDRM_OFF_ID3: variant_r[6:0] <= reg_wdata[7:1];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // boot sequencer: otp first, then optional eeprom block read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SIDRM_IDLE;
      tries_r <= 5'h00;
      byte_r <= 8'h00;
      crc_r <= 8'h00;
      eep_fast_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      unique case (st_r)
        SIDRM_IDLE: st_r <= SIDRM_OTP;
        SIDRM_OTP: if (otp_done) begin
          st_r <= skip_eeprom_load_r ? SIDRM_DONE : SIDRM_EEP;
          byte_r <= 8'h00;
          tries_r <= 5'h00;
          crc_r <= 8'h00;
        end
        SIDRM_EEP: begin
          if (eep_lost_arb) begin
            // first attempt plus the programmed number of retries
            if (tries_r >= eeprom_retry_count_r) begin
              fail_r <= 1'b1;
              st_r <= SIDRM_DONE;
            end else begin
              tries_r <= tries_r + 5'h01;
            end
          end else if (eep_nack) begin
            fail_r <= 1'b1;
            st_r <= SIDRM_DONE;
          end else if (eep_ack) begin
            if (load_last) begin
              fail_r <= (crc_r != eep_rdata);
              st_r <= SIDRM_DONE;
            end else begin
              crc_r <= crc8(crc_r, eep_rdata);
              byte_r <= byte_r + 8'h01;
              if (byte_r == SIDRM_SPEED_BYTE && eep_rdata[0]) begin
                eep_fast_r <= 1'b1;
              end
            end
          end
        end
        SIDRM_DONE: ;
      endcase
    end
  end

  // engine requests; eep_fast commits as soon as the speed byte arrives, before the checksum byte is checked
  assign otp_req = (st_r == SIDRM_OTP);
  assign otp_len = skip_otp_load_r ? SIDRM_OTP_BYTES : 8'hff;
  assign eep_req = (st_r == SIDRM_EEP);
  assign eep_dev_addr = eeprom_bus_address_r;
  assign eep_wide = eeprom_wide_offset_r;
  assign eep_offset = {8'h00, byte_r};
  assign eep_fast = eep_fast_r;
  assign load_failed_flag = fail_r;

  // ==========================================================
  // read-back path, one cycle latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd && acc_ok;
      if (reg_rd && acc_ok) begin
        unique case (reg_addr)
          SIDRM_OFF_BOOT_CTRL: rdata_r <= {eeprom_retry_count_r, rsvd_r, skip_otp_load_r, skip_eeprom_load_r};
          SIDRM_OFF_TARGET: rdata_r <= {eeprom_wide_offset_r, eeprom_bus_address_r};
          SIDRM_OFF_ID0: rdata_r <= {revision_code_r, part_code_r[15:12]};
          SIDRM_OFF_ID1: rdata_r <= part_code_r[11:4];
          SIDRM_OFF_ID2: rdata_r <= {part_code_r[3:0], variant_r[10:7]};
          SIDRM_OFF_ID3: rdata_r <= {variant_r[6:1], 2'b11};
          SIDRM_OFF_BOOT_STAT: rdata_r <= {7'h00, fail_r};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ==========================================================
  // checks
  blocked_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    load_busy && reg_rd |=> !reg_rvalid) else $error("read answered during load");
  nack_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == SIDRM_EEP) && !eep_lost_arb && eep_nack |=> load_failed_flag && !load_busy)
    else $error("nack did not fail load");
  skip_eep_a: assert property (@(posedge clk) disable iff (!rst_n)
    otp_req && otp_done && skip_eeprom_load_r |=> !eep_req) else $error("eeprom used when skipped");
  otp_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    otp_req && skip_otp_load_r |-> otp_len == 8'h08) else $error("otp length wrong");
  fast_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
    eep_req && eep_ack && !eep_lost_arb && !eep_nack && byte_r == 8'h05 && eep_rdata[0] |=> eep_fast)
    else $error("speed not raised");
  retry_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    eep_req && eep_lost_arb && tries_r < eeprom_retry_count_r |=> eep_req) else $error("gave up early");
  target_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    eep_req |-> eep_dev_addr == eeprom_bus_address_r && eep_wide == eeprom_wide_offset_r)
    else $error("eeprom target wrong");
  id_low_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && acc_ok && reg_addr == 10'h005 |=> reg_rdata[1:0] == 2'b11) else $error("id ones missing");
  decode_id_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_addr == 10'h003 |-> reg_blk == SIDRM_BLK_ID) else $error("id decode wrong");
  decode_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_addr == 10'h050 |-> reg_blk == SIDRM_BLK_RSVD) else $error("reserved decode wrong");

  load_ok_c: cover property (@(posedge clk) disable iff (!rst_n) eep_req ##1 !load_busy && !load_failed_flag);
  load_fail_c: cover property (@(posedge clk) disable iff (!rst_n) eep_req && eep_nack);
  retry_c: cover property (@(posedge clk) disable iff (!rst_n) eep_req && eep_lost_arb ##1 eep_req);
endmodule

// ===== sim/sidrm_boot_model.sv
// partner model: otp loader and boot serial eeprom behind the load link
`timescale 1ns/1ps
module sidrm_boot_model #(
  parameter int OTP_CYCLES = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic otp_req,
  input wire logic [7:0] otp_len,
  input wire logic eep_req,
  input wire logic [6:0] eep_dev_addr,
  input wire logic eep_wide,
  input wire logic [15:0] eep_offset,
  input wire logic eep_fast,
  output logic otp_done,
  output logic eep_lost_arb,
  output logic eep_ack,
  output logic eep_nack,
  output logic [7:0] eep_rdata
);
  import sidrm_pkg::*;
  int otp_cnt;
  // ==========================================================
  // eeprom image
  function automatic logic [7:0] raw(input logic [7:0] off);
    return (off == SIDRM_SPEED_BYTE) ? 8'h01 : (off ^ 8'h5a);
  endfunction
  // checksum byte is crc8 poly 07 over every byte before it
  function automatic logic [7:0] image(input logic [7:0] off);
    logic [7:0] c;
    c = 8'h00;
    if (off != SIDRM_CRC_BYTE) return raw(off);
    for (int i = 0; i < 132; i++) begin
      c = c ^ raw(i[7:0]);
      for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction
  // ==========================================================
  // otp phase: slow on purpose so the bench can poke the port meanwhile
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_cnt <= 0;
      otp_done <= 1'b0;
    end else begin
      otp_done <= 1'b0;
      if (otp_req && !otp_done) begin
        otp_cnt <= otp_cnt + 1;
        if (otp_cnt == OTP_CYCLES) begin
          otp_done <= 1'b1;
          otp_cnt <= 0;
        end
      end
    end
  end
  // eeprom answers every other cycle; idle data toggles, never holds stale
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eep_ack <= 1'b0;
      eep_rdata <= 8'h00;
    end else if (eep_req && !eep_ack) begin
      eep_ack <= 1'b1;
      eep_rdata <= image(eep_offset[7:0]);
    end else begin
      eep_ack <= 1'b0;
      eep_rdata <= ~eep_rdata;
    end
  end
  assign eep_lost_arb = 1'b0;
  assign eep_nack = 1'b0;
endmodule

// ===== sim/sidrm_top_tb.sv
// testbench: register reads and writes, block map, refusal while loading
`timescale 1ns/1ps
module sidrm_top_tb;
  import sidrm_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, otp_req, otp_done, eep_req, eep_wide, eep_fast;
  logic eep_lost_arb, eep_ack, eep_nack, load_busy, load_failed_flag, ok, eep_seen;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, otp_len, eep_rdata, d;
  logic [6:0] eep_dev_addr;
  logic [15:0] eep_offset;
  sidrm_blk_e reg_blk;
  int fails, check_count;
  // block map table: low bound, high bound, block
  logic [9:0] blo [21] = '{10'h000, 10'h002, 10'h006, 10'h008, 10'h030, 10'h039, 10'h03f, 10'h04b, 10'h057,
    10'h063, 10'h068, 10'h06c, 10'h071, 10'h079, 10'h07a, 10'h07c, 10'h200, 10'h202, 10'h20c, 10'h20d, 10'h213};
  logic [9:0] bhi [21] = '{10'h001, 10'h005, 10'h007, 10'h02f, 10'h038, 10'h03e, 10'h04a, 10'h056, 10'h062,
    10'h067, 10'h06b, 10'h070, 10'h078, 10'h079, 10'h07b, 10'h1ff, 10'h201, 10'h20b, 10'h20c, 10'h212, 10'h3ff};
  sidrm_blk_e bexp [21] = '{SIDRM_BLK_STARTUP, SIDRM_BLK_ID, SIDRM_BLK_SIF, SIDRM_BLK_DPLL, SIDRM_BLK_GPIO,
    SIDRM_BLK_ODRV, SIDRM_BLK_IDIV, SIDRM_BLK_RSVD, SIDRM_BLK_FDIV, SIDRM_BLK_DSRC, SIDRM_BLK_APLL,
    SIDRM_BLK_PDLA, SIDRM_BLK_IMON, SIDRM_BLK_IEN, SIDRM_BLK_FACT, SIDRM_BLK_RSVD, SIDRM_BLK_ISTAT,
    SIDRM_BLK_DSTAT, SIDRM_BLK_GPIS, SIDRM_BLK_GSTAT, SIDRM_BLK_RSVD};
  // ==========================================================
  // design and far side
  sidrm_top u_sidrm_top (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_blk(reg_blk),
    .otp_req(otp_req), .otp_len(otp_len), .otp_done(otp_done), .eep_req(eep_req), .eep_dev_addr(eep_dev_addr),
    .eep_wide(eep_wide), .eep_offset(eep_offset), .eep_fast(eep_fast), .eep_lost_arb(eep_lost_arb),
    .eep_ack(eep_ack), .eep_nack(eep_nack), .eep_rdata(eep_rdata), .load_busy(load_busy),
    .load_failed_flag(load_failed_flag));
  sidrm_boot_model u_sidrm_boot_model (.clk(clk), .rst_n(rst_n), .otp_req(otp_req), .otp_len(otp_len),
    .eep_req(eep_req), .eep_dev_addr(eep_dev_addr), .eep_wide(eep_wide), .eep_offset(eep_offset),
    .eep_fast(eep_fast), .otp_done(otp_done), .eep_lost_arb(eep_lost_arb), .eep_ack(eep_ack),
    .eep_nack(eep_nack), .eep_rdata(eep_rdata));
  // ==========================================================
  // clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // remembers any eeprom phase; reset values keep the eeprom out of play
  always @(posedge clk) begin
    if (eep_req === 1'b1) eep_seen <= 1'b1;
  end
  // ==========================================================
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    check_count++;
    if (((got ^ exp) & mask) !== 32'h0000_0000) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // read is taken at the edge, answer stands in the following cycle
  task automatic rd(input logic [9:0] a, output logic [7:0] dd, output logic okk);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    okk = reg_rvalid;
    dd = reg_rdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] mask);
    rd(a, d, ok);
    cmp({31'h0, ok}, 32'h0000_0001, 32'h0000_0001);
    cmp({24'h0, d}, {24'h0, exp}, {24'h0, mask});
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (load_busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 500) begin
      cmp({31'h0, load_busy}, 32'h0000_0000, 32'h0000_0001);
      tally_and_finish();
    end
  endtask
  // reserved bit 2 of the control byte reads back as written (reset 0), but it is masked
  task automatic chk_defaults();
    chk(SIDRM_OFF_BOOT_CTRL, 8'h09, 8'hfb);
    chk(SIDRM_OFF_TARGET, 8'h50, 8'hff);
    chk(SIDRM_OFF_ID0, 8'h01, 8'hff);
    chk(SIDRM_OFF_ID1, 8'h23, 8'hff);
    chk(SIDRM_OFF_ID2, 8'h40, 8'hff);
    chk(SIDRM_OFF_ID3, 8'hab, 8'hff);
    chk(SIDRM_OFF_BOOT_STAT, 8'h00, 8'h01);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    eep_seen = 1'b0;
    fails = 0;
    check_count = 0;
    do_reset();
    repeat (3) @(posedge clk);
    #1;
    cmp({31'h0, otp_req}, 32'h0000_0001, 32'h0000_0001);
    cmp({24'h0, otp_len}, 32'h0000_00ff, 32'h0000_00ff);
    rd(SIDRM_OFF_TARGET, d, ok);
    cmp({31'h0, ok}, 32'h0000_0000, 32'h0000_0001);
    wr(SIDRM_OFF_TARGET, 8'h11);
    wait_idle();
    cmp({31'h0, eep_seen}, 32'h0000_0000, 32'h0000_0001);
    cmp({31'h0, load_failed_flag}, 32'h0000_0000, 32'h0000_0001);
    cmp({31'h0, eep_fast}, 32'h0000_0000, 32'h0000_0001);
    chk_defaults();
    // writes read back, each checked field moved off its default value
    wr(SIDRM_OFF_BOOT_CTRL, 8'hf2);
    chk(SIDRM_OFF_BOOT_CTRL, 8'hf2, 8'hfb);
    cmp({24'h0, otp_len}, 32'h0000_0008, 32'h0000_00ff);
    wr(SIDRM_OFF_TARGET, 8'hab);
    chk(SIDRM_OFF_TARGET, 8'hab, 8'hff);
    cmp({25'h0, eep_dev_addr}, 32'h0000_002b, 32'h0000_007f);
    cmp({31'h0, eep_wide}, 32'h0000_0001, 32'h0000_0001);
    wr(SIDRM_OFF_ID0, 8'h5a);
    chk(SIDRM_OFF_ID0, 8'h5a, 8'hff);
    wr(SIDRM_OFF_ID1, 8'hc3);
    chk(SIDRM_OFF_ID1, 8'hc3, 8'hff);
    wr(SIDRM_OFF_ID2, 8'h96);
    chk(SIDRM_OFF_ID2, 8'h96, 8'hff);
    wr(SIDRM_OFF_ID3, 8'ha4);
    chk(SIDRM_OFF_ID3, 8'ha7, 8'hff);
    // block map: both bounds of every range
    for (int i = 0; i < 21; i++) begin
      @(posedge clk);
      reg_addr <= blo[i];
      @(posedge clk);
      cmp(32'(reg_blk), 32'(bexp[i]), 32'hffff_ffff);
      reg_addr <= bhi[i];
      @(posedge clk);
      cmp(32'(reg_blk), 32'(bexp[i]), 32'hffff_ffff);
    end
    // second reset mid-run brings every field back to its default
    do_reset();
    wait_idle();
    chk_defaults();
    tally_and_finish();
  end
endmodule
